// >>> logic/brltc_top.sv
// Branch, loop and software trap resolution for the core
`timescale 1ns/100ps
`default_nettype none
module brltc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [brltc_pkg::REG_ADDR_W-1:0] reg_addr,
    input wire logic [brltc_pkg::REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [brltc_pkg::REG_DATA_W-1:0] reg_rdata,
    // Instruction request
    input wire logic req_valid,
    input wire brltc_pkg::brltc_op_t req_op,
    input wire brltc_pkg::brltc_cond_t req_cond,
    input wire logic [brltc_pkg::IP_W-1:0] req_ip,
    input wire logic [3:0] req_len,
    input wire logic [brltc_pkg::DISP_W-1:0] req_disp,
    input wire logic [7:0] req_vector,
    input wire logic req_opsize16,
    input wire logic req_addr16,
    input wire logic req_addr_ovr32,
    // Architectural state seen by the request
    input wire logic carry_flag,
    input wire logic zero_flag,
    input wire logic overflow_flag,
    input wire logic parity_flag,
    input wire logic sign_flag,
    input wire logic [31:0] flags_reg,
    input wire logic [63:0] count_reg64,
    input wire logic [31:0] bound_value,
    input wire logic [31:0] bound_lower,
    input wire logic [31:0] bound_upper,
    input wire logic [brltc_pkg::IP_W-1:0] stack_ip,
    input wire logic [31:0] stack_flags,
    input wire logic [1:0] current_priv_level,
    input wire logic [1:0] return_priv_level,
    // Resolution result
    output logic res_valid,
    output logic res_taken,
    output logic [brltc_pkg::IP_W-1:0] res_next_ip,
    output logic res_count_we,
    output logic [63:0] res_count,
    output logic res_exc,
    output logic [7:0] res_exc_vector,
    output logic res_push_flags,
    output logic [31:0] res_push_flags_val,
    output logic [brltc_pkg::IP_W-1:0] res_push_ip,
    output logic res_restore_flags,
    output logic [31:0] res_flags,
    output logic [3:0] res_pop_bytes,
    output logic res_pop_stack_seg_and_ptr,
    output logic res_size64
);
    import brltc_pkg::*;

    brltc_eval_if ev ();

    brltc_cond_eval u_cond (
        .ev(ev)
    );

    brltc_count_unit u_count (
        .ev(ev)
    );

    // Software-held state
    logic [CTRL_MODE_W-1:0] ctrl_mode;
    brltc_mode_t mode;
    logic long64;
    logic [31:0] taken_cnt;
    logic [31:0] exc_cnt;
    logic [31:0] loop_cnt;

    // Combinational resolution
    logic [63:0] fall_ip;
    logic [63:0] target_ip;
    logic [63:0] disp_sext;
    logic bound_fail;
    brltc_asz_t loop_asz;
    logic next_taken;
    logic [63:0] next_ip;
    logic next_count_we;
    logic next_exc;
    logic [7:0] next_vector;
    logic next_restore;
    logic [3:0] next_pop_bytes;
    logic next_pop_ss;
    logic next_size64;
    logic is_loop;

    // Illegal mode code behaves as legacy so a bad write cannot wedge the block
    always_comb begin
        unique case (ctrl_mode)
            2'h1: mode = MODE_COMPAT;
            2'h2: mode = MODE_LONG64;
            default: mode = MODE_LEGACY;
        endcase
    end
    assign long64 = (mode == MODE_LONG64);

    // Pointer width follows operand size; full width in 64-bit mode
    function automatic logic [63:0] trunc_ip(input logic [63:0] ip, input logic l64, input logic os16);
        logic [63:0] r;
        r = ip;
        if (l64) begin
            r = ip;
        end else if (os16) begin
            r = {48'h000000000000, ip[15:0]};
        end else begin
            r = {32'h00000000, ip[31:0]};
        end
        return r;
    endfunction

    // Displacement is never wider than 32 bits, even in 64-bit mode
    assign disp_sext = {{32{req_disp[DISP_W-1]}}, req_disp};
    assign fall_ip = req_ip + {60'h000000000000000, req_len};
    assign target_ip = fall_ip + disp_sext;

    // Address size is a separate attribute, defaulting to 64 in 64-bit mode
    always_comb begin
        if (long64) begin
            loop_asz = req_addr_ovr32 ? ASZ_32 : ASZ_64;
        end else begin
            loop_asz = req_addr16 ? ASZ_16 : ASZ_32;
        end
    end

    assign ev.carry_flag = carry_flag;
    assign ev.zero_flag = zero_flag;
    assign ev.overflow_flag = overflow_flag;
    assign ev.parity_flag = parity_flag;
    assign ev.sign_flag = sign_flag;
    assign ev.cond = req_cond;
    assign ev.count_in = count_reg64;

    always_comb begin
        unique case (req_op)
            OP_JUMP_CNT16_ZERO: ev.asz = ASZ_16;
            OP_JUMP_CNT32_ZERO: ev.asz = (loop_asz == ASZ_16) ? ASZ_32 : loop_asz;
            default: ev.asz = loop_asz;
        endcase
    end

    assign bound_fail = ($signed(bound_value) < $signed(bound_lower))
                        || ($signed(bound_value) > $signed(bound_upper));

    assign is_loop = (req_op == OP_LOOP) || (req_op == OP_LOOP_WHILE_EQ) || (req_op == OP_LOOP_WHILE_NE);

    always_comb begin
        next_taken = 1'b0;
        next_ip = trunc_ip(fall_ip, long64, req_opsize16);
        next_count_we = 1'b0;
        next_exc = 1'b0;
        next_vector = 8'h00;
        next_restore = 1'b0;
        next_pop_bytes = 4'h0;
        next_pop_ss = 1'b0;
        next_size64 = long64;
        unique case (req_op)
            OP_JCC: begin
                next_taken = ev.cond_true;
            end
            OP_JUMP_CNT16_ZERO, OP_JUMP_CNT32_ZERO: begin
                next_taken = ev.cnt_zero;
            end
            OP_LOOP: begin
                next_count_we = 1'b1;
                next_taken = ev.dec_nonzero;
            end
            OP_LOOP_WHILE_EQ: begin
                next_count_we = 1'b1;
                next_taken = ev.dec_nonzero && zero_flag;
            end
            OP_LOOP_WHILE_NE: begin
                next_count_we = 1'b1;
                next_taken = ev.dec_nonzero && !zero_flag;
            end
            OP_INT_N: begin
                next_exc = 1'b1;
                next_vector = req_vector;
            end
            OP_INT_OVF: begin
                next_exc = overflow_flag;
                next_vector = VEC_OVERFLOW;
            end
            OP_BOUND: begin
                if (long64) begin
                    next_exc = 1'b1;
                    next_vector = VEC_UNSUPPORTED;
                end else begin
                    next_exc = bound_fail;
                    next_vector = VEC_RANGE;
                end
            end
            OP_INTERRUPT_RETURN: begin
                next_taken = 1'b1;
                next_restore = 1'b1;
                next_ip = trunc_ip(stack_ip, long64, req_opsize16);
                if (long64) begin
                    next_pop_bytes = ITEM_BYTES_64;
                    next_pop_ss = 1'b1;
                end else begin
                    next_pop_bytes = req_opsize16 ? ITEM_BYTES_16 : ITEM_BYTES_32;
                    next_pop_ss = (return_priv_level != current_priv_level);
                end
            end
            default: begin
                next_taken = 1'b0;
            end
        endcase
        if (next_taken && (req_op != OP_INTERRUPT_RETURN)) begin
            next_ip = trunc_ip(target_ip, long64, req_opsize16);
        end
    end

    // Result stage: one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
            res_taken <= 1'b0;
            res_next_ip <= 64'h0000000000000000;
            res_count_we <= 1'b0;
            res_count <= 64'h0000000000000000;
            res_exc <= 1'b0;
            res_exc_vector <= 8'h00;
            res_restore_flags <= 1'b0;
            res_flags <= 32'h00000000;
            res_pop_bytes <= 4'h0;
            res_pop_stack_seg_and_ptr <= 1'b0;
            res_size64 <= 1'b0;
        end else begin
            res_valid <= req_valid;
            res_taken <= req_valid && next_taken;
            res_count_we <= req_valid && next_count_we;
            res_exc <= req_valid && next_exc;
            res_restore_flags <= req_valid && next_restore;
            res_pop_stack_seg_and_ptr <= req_valid && next_pop_ss;
            if (req_valid) begin
                res_next_ip <= next_ip;
                res_count <= next_count_we ? ev.cnt_dec : count_reg64;
                res_exc_vector <= next_vector;
                res_flags <= stack_flags;
                res_pop_bytes <= next_pop_bytes;
                res_size64 <= next_size64;
            end
        end
    end

    // Frame pushed on a raised interrupt: flags beside the return pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            res_push_flags <= 1'b0;
            res_push_flags_val <= 32'h00000000;
            res_push_ip <= 64'h0000000000000000;
        end else begin
            res_push_flags <= req_valid && next_exc;
            if (req_valid && next_exc) begin
                res_push_flags_val <= flags_reg;
                res_push_ip <= trunc_ip(fall_ip, long64, req_opsize16);
            end
        end
    end

    // Mode control
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_mode <= CTRL_MODE_RESET;
        end else if (reg_wr && (reg_addr == REG_CTRL)) begin
            ctrl_mode <= reg_wdata[CTRL_MODE_LSB +: CTRL_MODE_W];
        end
    end

    // Event counters: a write clears, but a same-cycle event still counts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taken_cnt <= 32'h00000000;
        end else if (reg_wr && (reg_addr == REG_TAKEN_CNT)) begin
            taken_cnt <= {31'h00000000, res_taken};
        end else if (res_taken) begin
            taken_cnt <= taken_cnt + CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            exc_cnt <= 32'h00000000;
        end else if (reg_wr && (reg_addr == REG_EXC_CNT)) begin
            exc_cnt <= {31'h00000000, res_exc};
        end else if (res_exc) begin
            exc_cnt <= exc_cnt + CNT_ONE;
        end
    end

    // Counts loop iterations that branched back
    logic loop_hit;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_hit <= 1'b0;
        end else begin
            loop_hit <= req_valid && is_loop && next_taken;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            loop_cnt <= 32'h00000000;
        end else if (reg_wr && (reg_addr == REG_LOOP_CNT)) begin
            loop_cnt <= {31'h00000000, loop_hit};
        end else if (loop_hit) begin
            loop_cnt <= loop_cnt + CNT_ONE;
        end
    end

    // Read data in the cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: reg_rdata <= {30'h00000000, ctrl_mode};
                REG_STATUS: begin
                    reg_rdata <= 32'h00000000;
                    reg_rdata[ST_TAKEN_BIT] <= res_taken;
                    reg_rdata[ST_EXC_BIT] <= res_exc;
                    reg_rdata[ST_POP_SS_BIT] <= res_pop_stack_seg_and_ptr;
                    reg_rdata[ST_SIZE64_BIT] <= res_size64;
                    reg_rdata[ST_VEC_LSB +: 8] <= res_exc_vector;
                    reg_rdata[ST_POP_BYTES_LSB +: 4] <= res_pop_bytes;
                end
                REG_TAKEN_CNT: reg_rdata <= taken_cnt;
                REG_EXC_CNT: reg_rdata <= exc_cnt;
                REG_LOOP_CNT: reg_rdata <= loop_cnt;
                REG_LAST_IP_LO: reg_rdata <= res_next_ip[31:0];
                REG_LAST_IP_HI: reg_rdata <= res_next_ip[63:32];
                default: reg_rdata <= 32'h00000000;
            endcase
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

// >>> logic/brltc_pkg.sv
// Shared types and constants of the branch, loop and trap control block
package brltc_pkg;

    // Register port geometry and request pointer and displacement widths
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;
    localparam int IP_W = 64;
    localparam int DISP_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_TAKEN_CNT = 8'h08;
    localparam logic [7:0] REG_EXC_CNT = 8'h0C;
    localparam logic [7:0] REG_LOOP_CNT = 8'h10;
    localparam logic [7:0] REG_LAST_IP_LO = 8'h14;
    localparam logic [7:0] REG_LAST_IP_HI = 8'h18;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 2;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;

    // Status register fields
    localparam int ST_TAKEN_BIT = 0;
    localparam int ST_EXC_BIT = 1;
    localparam int ST_POP_SS_BIT = 2;
    localparam int ST_SIZE64_BIT = 3;
    localparam int ST_VEC_LSB = 8;
    localparam int ST_POP_BYTES_LSB = 16;

    // Exception vectors; default values are arbitrary and may be re-assigned
    localparam logic [7:0] VEC_OVERFLOW = 8'h04;
    localparam logic [7:0] VEC_RANGE = 8'h05;
    localparam logic [7:0] VEC_UNSUPPORTED = 8'h06;

    // Stack item sizes in bytes
    localparam logic [3:0] ITEM_BYTES_16 = 4'h2;
    localparam logic [3:0] ITEM_BYTES_32 = 4'h4;
    localparam logic [3:0] ITEM_BYTES_64 = 4'h8;

    localparam logic [31:0] CNT_ONE = 32'h00000001;

    typedef enum logic [3:0] {
        OP_JCC, OP_JUMP_CNT16_ZERO, OP_JUMP_CNT32_ZERO, OP_LOOP, OP_LOOP_WHILE_EQ,
        OP_LOOP_WHILE_NE, OP_INT_N, OP_INT_OVF, OP_BOUND, OP_INTERRUPT_RETURN
    } brltc_op_t;

    typedef enum logic [3:0] {
        CC_O, CC_NO, CC_B, CC_AE, CC_E, CC_NE, CC_BE, CC_A,
        CC_S, CC_NS, CC_P, CC_NP, CC_L, CC_GE, CC_LE, CC_G
    } brltc_cond_t;

    typedef enum logic [1:0] {MODE_LEGACY, MODE_COMPAT, MODE_LONG64} brltc_mode_t;

    typedef enum logic [1:0] {ASZ_16, ASZ_32, ASZ_64} brltc_asz_t;

endpackage

// >>> logic/brltc_eval_if.sv
// Carrier between the control core and its condition and count evaluators
`timescale 1ns/100ps
`default_nettype none
interface brltc_eval_if;
    import brltc_pkg::*;
    logic carry_flag;
    logic zero_flag;
    logic overflow_flag;
    logic parity_flag;
    logic sign_flag;
    brltc_cond_t cond;
    logic cond_true;
    logic [63:0] count_in;
    brltc_asz_t asz;
    logic cnt_zero;
    logic [63:0] cnt_dec;
    logic dec_nonzero;

    modport core (output carry_flag, zero_flag, overflow_flag, parity_flag, sign_flag, cond, count_in, asz,
                  input cond_true, cnt_zero, cnt_dec, dec_nonzero);
    modport cond_side (input carry_flag, zero_flag, overflow_flag, parity_flag, sign_flag, cond,
                       output cond_true);
    modport cnt_side (input count_in, asz, output cnt_zero, cnt_dec, dec_nonzero);
endinterface
`default_nettype wire

// >>> logic/brltc_cond_eval.sv
// Flag condition evaluator for conditional jumps
`timescale 1ns/100ps
`default_nettype none
module brltc_cond_eval (
    // Flags and condition in, verdict out
    brltc_eval_if.cond_side ev
);
    import brltc_pkg::*;
    logic less;
    logic below_eq;

    // Unsigned compares use carry and zero, signed ones sign xor overflow
    assign less = ev.sign_flag ^ ev.overflow_flag;
    assign below_eq = ev.carry_flag | ev.zero_flag;

    always_comb begin
        unique case (ev.cond)
            CC_O: ev.cond_true = ev.overflow_flag;
            CC_NO: ev.cond_true = !ev.overflow_flag;
            CC_B: ev.cond_true = ev.carry_flag;
            CC_AE: ev.cond_true = !ev.carry_flag;
            CC_E: ev.cond_true = ev.zero_flag;
            CC_NE: ev.cond_true = !ev.zero_flag;
            CC_BE: ev.cond_true = below_eq;
            CC_A: ev.cond_true = !below_eq;
            CC_S: ev.cond_true = ev.sign_flag;
            CC_NS: ev.cond_true = !ev.sign_flag;
            CC_P: ev.cond_true = ev.parity_flag;
            CC_NP: ev.cond_true = !ev.parity_flag;
            CC_L: ev.cond_true = less;
            CC_GE: ev.cond_true = !less;
            CC_LE: ev.cond_true = less | ev.zero_flag;
            CC_G: ev.cond_true = !(less | ev.zero_flag);
        endcase
    end
endmodule
`default_nettype wire

// >>> logic/brltc_count_unit.sv
// Count register test and decrement at the selected address size
`timescale 1ns/100ps
`default_nettype none
module brltc_count_unit (
    // Count and size in, tests and decremented count out
    brltc_eval_if.cnt_side ev
);
    import brltc_pkg::*;
    logic [15:0] dec16;
    logic [31:0] dec32;
    logic [63:0] dec64;

    // Zero wraps to all ones, so a loop entered at zero runs the full range
    assign dec16 = ev.count_in[15:0] - CNT_ONE[15:0];
    assign dec32 = ev.count_in[31:0] - CNT_ONE;
    assign dec64 = ev.count_in - {32'h00000000, CNT_ONE};

    always_comb begin
        unique case (ev.asz)
            ASZ_16: begin
                ev.cnt_zero = (ev.count_in[15:0] == 16'h0000);
                ev.cnt_dec = {ev.count_in[63:16], dec16};
                ev.dec_nonzero = (dec16 != 16'h0000);
            end
            ASZ_32: begin
                ev.cnt_zero = (ev.count_in[31:0] == 32'h00000000);
                ev.cnt_dec = {ev.count_in[63:32], dec32};
                ev.dec_nonzero = (dec32 != 32'h00000000);
            end
            default: begin
                ev.cnt_zero = (ev.count_in == 64'h0000000000000000);
                ev.cnt_dec = dec64;
                ev.dec_nonzero = (dec64 != 64'h0000000000000000);
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> tb/brltc_assertions.sv
// Port-level checks of branch, loop and trap resolution
`timescale 1ns/100ps
`default_nettype none
module brltc_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request
    input wire logic req_valid,
    input wire brltc_pkg::brltc_op_t req_op,
    input wire brltc_pkg::brltc_cond_t req_cond,
    input wire logic [7:0] req_vector,
    input wire logic zero_flag,
    input wire logic overflow_flag,
    input wire logic [63:0] count_reg64,
    input wire logic [31:0] bound_value,
    input wire logic [31:0] bound_lower,
    input wire logic [31:0] stack_flags,
    // Result
    input wire logic res_taken,
    input wire logic res_count_we,
    input wire logic res_exc,
    input wire logic [7:0] res_exc_vector,
    input wire logic res_push_flags,
    input wire logic res_restore_flags,
    input wire logic [31:0] res_flags,
    input wire logic [3:0] res_pop_bytes,
    input wire logic res_pop_stack_seg_and_ptr,
    input wire logic res_size64
);
    import brltc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_jcc_equal_zf: assert property (req_valid && req_op == OP_JCC && req_cond == CC_E
        |=> res_taken == $past(zero_flag)) else $error("equal jump ignores zero flag");
    a_cnt16_zero: assert property (req_valid && req_op == OP_JUMP_CNT16_ZERO
        |=> res_taken == ($past(count_reg64[15:0]) == 16'h0)) else $error("16-bit count test wrong");
    a_cnt32_keep: assert property (req_valid && req_op == OP_JUMP_CNT32_ZERO |=> !res_count_we)
        else $error("count-zero jump wrote count");
    a_int_vector: assert property (req_valid && req_op == OP_INT_N
        |=> res_exc && res_exc_vector == $past(req_vector)) else $error("software vector wrong");
    a_ovf_trap: assert property (req_valid && req_op == OP_INT_OVF
        |=> res_exc == $past(overflow_flag)) else $error("overflow trap wrong");
    a_bound_low: assert property (req_valid && req_op == OP_BOUND
        && $signed(bound_value) < $signed(bound_lower) |=> res_exc) else $error("low bound missed");
    a_push_frame: assert property (res_exc |-> res_push_flags) else $error("no frame push");
    a_interrupt_return_flags: assert property (req_valid && req_op == OP_INTERRUPT_RETURN
        |=> res_restore_flags && res_flags == $past(stack_flags)) else $error("flags not restored");
    a_interrupt_return_pop64: assert property (res_restore_flags && res_size64
        |-> res_pop_bytes == ITEM_BYTES_64 && res_pop_stack_seg_and_ptr) else $error("wide pop wrong");
    c_loop_taken: cover property (res_count_we && res_taken);
    c_trap: cover property (res_exc);
    c_interrupt_return: cover property (res_restore_flags);
endmodule
bind brltc_top brltc_checker u_chk (.*);
`default_nettype wire

// >>> tb/testbench.sv
// Random and corner-case bench of branch, loop and trap resolution
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import brltc_pkg::*;
    logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, req_valid = 1'h0;
    logic req_opsize16 = 1'h0, req_addr16 = 1'h0, req_addr_ovr32 = 1'h0;
    logic carry_flag = 1'h0, zero_flag = 1'h0, overflow_flag = 1'h0, parity_flag = 1'h0, sign_flag = 1'h0;
    logic [1:0] current_priv_level = 2'h0, return_priv_level = 2'h0;
    logic [3:0] req_len = 4'h2;
    logic [7:0] reg_addr = 8'h0, req_vector = 8'h0;
    logic [31:0] reg_wdata = '0, req_disp = '0, flags_reg = '0, bound_value = '0;
    logic [31:0] bound_lower = 32'hFFFFFFFB, bound_upper = 32'h5, stack_flags = '0;
    logic [63:0] req_ip = '0, count_reg64 = '0, stack_ip = '0;
    brltc_op_t req_op = OP_JCC;
    brltc_cond_t req_cond = CC_O;
    logic res_valid, res_taken, res_count_we, res_exc, res_push_flags, res_restore_flags;
    logic res_pop_stack_seg_and_ptr, res_size64;
    logic [3:0] res_pop_bytes;
    logic [7:0] res_exc_vector;
    logic [31:0] reg_rdata, res_push_flags_val, res_flags;
    logic [63:0] res_next_ip, res_count, res_push_ip, e_c, e_ip, rd;
    logic e_t;
    int failures = 0, compares = 0, i, seed = 32'h6CDF, n_loop = 2;
    brltc_top dut (.*);
    always #2.5 clk = ~clk;
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
    endtask
    task automatic reg_read(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        rd = reg_rdata;
    endtask
    // Fields are set before the call; the result is looked at just after the answer edge
    task automatic fire(input brltc_op_t op);
        @(posedge clk);
        req_op <= op;
        req_valid <= 1'h1;
        @(posedge clk);
        req_valid <= 1'h0;
        #1;
        check("valid", res_valid, 1'h1);
    endtask
    function automatic logic cond_exp(input logic [3:0] c);
        logic [7:0] r;
        r = {(sign_flag ^ overflow_flag) | zero_flag, sign_flag ^ overflow_flag, parity_flag, sign_flag,
             carry_flag | zero_flag, zero_flag, carry_flag, overflow_flag};
        return r[c[3:1]] ^ c[0];
    endfunction
    function automatic logic [63:0] sext(input logic t);
        return t ? {{32{req_disp[31]}}, req_disp} : 64'h0;
    endfunction
    initial begin
        #100000;
        failures++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        reg_read(REG_CTRL);
        check("ctrl reset", rd, CTRL_MODE_RESET);
        reg_read(8'h40);
        check("unmapped", rd, 64'h0);
        reg_write(REG_CTRL, 32'h2);
        for (i = 0; i < 64; i++) begin
            {carry_flag, zero_flag, overflow_flag, parity_flag, sign_flag} <= 5'($random(seed));
            req_cond <= brltc_cond_t'(i[3:0]);
            req_ip <= {$random(seed), $random(seed)};
            req_disp <= $random(seed);
            fire(OP_JCC);
            e_t = cond_exp(req_cond);
            check("jcc taken", res_taken, e_t);
            check("jcc ip", res_next_ip, req_ip + req_len + sext(e_t));
            check("size64", res_size64, 1'h1);
        end
        $display("test conditions done");
        count_reg64 <= 64'h100000000;
        req_addr_ovr32 <= 1'h1;
        fire(OP_JUMP_CNT32_ZERO);
        check("cnt32 ovr", res_taken, 1'h1);
        check("cnt32 we", res_count_we, 1'h0);
        fire(OP_LOOP);
        check("loop ovr", res_count, 64'h1FFFFFFFF);
        req_addr_ovr32 <= 1'h0;
        fire(OP_JUMP_CNT32_ZERO);
        check("cnt64", res_taken, 1'h0);
        fire(OP_JUMP_CNT16_ZERO);
        check("cnt16", res_taken, 1'h1);
        fire(OP_LOOP);
        check("loop 64", res_count, 64'hFFFFFFFF);
        reg_write(REG_CTRL, 32'h2);
        bound_value <= 32'h0;
        fire(OP_BOUND);
        check("bound64", res_exc_vector, VEC_UNSUPPORTED);
        reg_write(REG_CTRL, 32'h0);
        req_ip <= 64'h7FFFFFF0;
        for (i = 0; i < 24; i++) begin
            req_addr16 <= i[0];
            zero_flag <= i[1];
            count_reg64 <= i % 3 == 0 ? 64'h0 : i % 3 == 1 ? 64'h10001 : {$random(seed), $random(seed)};
            fire(i < 8 ? OP_LOOP : i < 16 ? OP_LOOP_WHILE_EQ : OP_LOOP_WHILE_NE);
            e_c = count_reg64;
            if (req_addr16) e_c[15:0] = e_c[15:0] - 16'h1;
            else e_c[31:0] = e_c[31:0] - 32'h1;
            e_t = (req_addr16 ? e_c[15:0] != 16'h0 : e_c[31:0] != 32'h0) && (i < 8 || zero_flag == (i < 16));
            e_ip = req_ip + req_len + sext(e_t);
            n_loop += e_t;
            check("loop we", res_count_we, 1'h1);
            check("loop count", res_count, e_c);
            check("loop taken", res_taken, e_t);
            check("loop ip", res_next_ip, {32'h0, e_ip[31:0]});
        end
        reg_read(REG_LOOP_CNT);
        check("loop cnt", rd, n_loop);
        for (i = 0; i < 4; i++) begin
            bound_value <= i[1] ? 32'h5 + i[0] : 32'hFFFFFFFA + i[0];
            fire(OP_BOUND);
            check("bound exc", res_exc, i[0] == i[1]);
        end
        for (i = 0; i < 8; i++) begin
            overflow_flag <= i[0];
            req_vector <= 8'($random(seed));
            flags_reg <= $random(seed);
            fire(i[1] ? OP_INT_N : OP_INT_OVF);
            check("trap exc", res_exc, i[1] | i[0]);
            check("push", res_push_flags, i[1] | i[0]);
            if (i[1] | i[0]) begin
                e_ip = req_ip + req_len;
                check("push ip", res_push_ip, {32'h0, e_ip[31:0]});
                check("trap vec", res_exc_vector, i[1] ? req_vector : VEC_OVERFLOW);
                check("push flags", res_push_flags_val, flags_reg);
            end
        end
        // Code 3 is illegal and must behave as legacy
        for (i = 0; i < 4; i++) begin
            e_c = i == 0 ? 64'h2 : i == 3 ? 64'h3 : 64'h1;
            reg_write(REG_CTRL, e_c[31:0]);
            reg_read(REG_CTRL);
            check("ctrl rd", rd, e_c);
            req_opsize16 <= i == 3;
            return_priv_level <= i == 2 ? 2'h3 : 2'h0;
            stack_ip <= {i ? 32'h0 : $random(seed), $random(seed)};
            stack_flags <= $random(seed);
            fire(OP_INTERRUPT_RETURN);
            check("interrupt_return ip", res_next_ip, i == 3 ? {48'h0, stack_ip[15:0]} : stack_ip);
            check("interrupt_return flags", res_flags, stack_flags);
            check("interrupt_return restore", res_restore_flags, 1'h1);
            check("interrupt_return size64", res_size64, i == 0);
            check("interrupt_return bytes", res_pop_bytes, i == 3 ? ITEM_BYTES_16 : i ? ITEM_BYTES_32 : ITEM_BYTES_64);
            check("interrupt_return pop", res_pop_stack_seg_and_ptr, !i[0]);
        end
        $display("test loops, traps and returns done");
        stop_test;
    end
endmodule
`default_nettype wire
